// File: core/io_addr_decode.sv
`include "io_space_params.svh"
module io_addr_decode
  import io_space_pkg::*;
(
  input  wire io_req_t    req_i,
  output logic            port_ok_o,
  output logic            data_ok_o,
  output logic            bit_ok_o,
  output logic [7:0]      dspace_o
);
  // Port and bit-op addresses are I/O numbers; data-space adds the offset
  always_comb begin
    port_ok_o = 1'b0;
    data_ok_o = 1'b0;
    bit_ok_o  = 1'b0;
    dspace_o  = req_i.addr;
    case (req_i.op)
      OP_PORT_IN, OP_PORT_OUT: begin
        port_ok_o = (req_i.addr <= `IO_PORT_LAST); // [RULE4]
        dspace_o  = 8'(req_i.addr + `IO_DATA_OFFSET); // [RULE5]
      end
      OP_SET_BIT, OP_CLEAR_BIT, OP_TEST_BIT: begin
        bit_ok_o = (req_i.addr <= `IO_BIT_LAST); // [RULE1]
        dspace_o = 8'(req_i.addr + `IO_DATA_OFFSET);
      end
      OP_DATA_LOAD, OP_DATA_STORE: begin
        data_ok_o = 1'b1; // [RULE6]
      end
      default: begin
      end
    endcase
  end
endmodule

// File: core/io_space_regs.sv
// How it works
// RULE1 - Low I/O range 0x00-0x1F supports bit set, clear and bit tests.
// RULE2 - Some status flags clear when one is written; zero leaves them.
// RULE3 - Bit set or clear touches only the addressed bit.
// RULE4 - Port in/out instructions use I/O addresses 0x00 to 0x3F.
// RULE5 - Data-space address of an I/O register is I/O address plus 0x20.
// RULE6 - Extended region 0x60-0xFF reachable only by loads and stores.
// RULE7 - Software should write zero to reserved bits.
// RULE8 - Software never writes reserved addresses.
// RULE9 - Reserved addresses and bits read zero; writes to them do nothing.
`include "io_space_params.svh"
module io_space_regs
  import io_space_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire io_req_t    req_i,
  input  wire logic [7:0] flag_set_i,
  output io_rsp_t         rsp_o,
  output logic [7:0]      low_flags_o,
  output logic [7:0]      low_ctrl_o,
  output logic [7:0]      adc_input_select_o,
  output logic [7:0]      adc_pin_digital_disable_o,
  output logic [7:0]      comparator_pin_digital_disable_o,
  output logic [7:0]      wide_timer_ctrl_a_o,
  output logic [7:0]      wide_timer_ctrl_b_o,
  output logic [7:0]      wide_timer_force_compare_o,
  output logic [15:0]     wide_timer_count_o,
  output logic [15:0]     wide_timer_capture_o,
  output logic [15:0]     wide_timer_compare_a_o,
  output logic [15:0]     wide_timer_compare_b_o
);
  logic       port_ok;
  logic       data_ok;
  logic       bit_ok;
  logic [7:0] dspace;

  io_addr_decode u_dec (
    .req_i     (req_i),
    .port_ok_o (port_ok),
    .data_ok_o (data_ok),
    .bit_ok_o  (bit_ok),
    .dspace_o  (dspace)
  );

  // Extended registers indexed by data-space offset from OFF_ADC_SEL (0x7C), not from the extended start
  logic [7:0] flags_reg, flags_next;
  logic [7:0] ctrl_reg,  ctrl_next;
  logic [7:0] ext_reg  [16];
  logic [7:0] ext_next [16];
  io_rsp_t    rsp_reg, rsp_next;

  function automatic logic [7:0] ext_mask(input logic [7:0] a);
    case (a)
      `OFF_ADC_SEL:     ext_mask = `MASK_ADC_SEL;
      `OFF_ADC_DIS:     ext_mask = 8'hFF;
      `OFF_CMP_DIS:     ext_mask = `MASK_CMP_DIS;
      `OFF_TMR_CTRL_A:  ext_mask = `MASK_TMR_CTRL_A;
      `OFF_TMR_CTRL_B:  ext_mask = `MASK_TMR_CTRL_B;
      `OFF_TMR_FORCE:   ext_mask = `MASK_TMR_FORCE;
      `OFF_TMR_CNT_L, `OFF_TMR_CNT_H, `OFF_TMR_CAP_L, `OFF_TMR_CAP_H,
      `OFF_TMR_CMPA_L, `OFF_TMR_CMPA_H, `OFF_TMR_CMPB_L,
      `OFF_TMR_CMPB_H:  ext_mask = 8'hFF;
      default:          ext_mask = 8'h00; // [RULE9]
    endcase
  endfunction

  function automatic logic [3:0] ext_idx(input logic [7:0] a);
    ext_idx = 4'(a - `OFF_ADC_SEL);
  endfunction

  function automatic logic in_ext_win(input logic [7:0] a);
    in_ext_win = (a >= `OFF_ADC_SEL) && (a <= `OFF_TMR_CMPB_H);
  endfunction

  logic       wr_en;
  logic       rd_en;
  logic [7:0] rd_val;
  logic [7:0] io_a;

  always_comb begin
    io_a  = 8'(dspace - `IO_DATA_OFFSET);
    wr_en = (req_i.op == OP_PORT_OUT && port_ok) ||
            (req_i.op == OP_DATA_STORE && data_ok);
    rd_en = (req_i.op == OP_PORT_IN && port_ok) ||
            (req_i.op == OP_DATA_LOAD && data_ok);
    rd_val = 8'h00;
    if (dspace == 8'(`OFF_LOW_FLAGS + `IO_DATA_OFFSET))
      rd_val = flags_reg;
    else if (dspace == 8'(`OFF_LOW_CTRL + `IO_DATA_OFFSET))
      rd_val = ctrl_reg;
    else if (dspace >= `EXT_FIRST && in_ext_win(dspace))
      rd_val = ext_reg[ext_idx(dspace)] & ext_mask(dspace); // [RULE6]
  end

  always_comb begin
    flags_next = flags_reg;
    ctrl_next  = ctrl_reg;
    for (int i = 0; i < 16; i++)
      ext_next[i] = ext_reg[i];
    rsp_next = '0;
    if (wr_en && io_a == `OFF_LOW_FLAGS)
      flags_next = flags_reg & ~req_i.wdata; // [RULE2]
    if (wr_en && io_a == `OFF_LOW_CTRL)
      ctrl_next = req_i.wdata;
    if (bit_ok && io_a == `OFF_LOW_FLAGS) begin
      if (req_i.op == OP_SET_BIT)
        flags_next[req_i.bit_sel] = 1'b0; // [RULE3]
    end
    if (bit_ok && io_a == `OFF_LOW_CTRL) begin
      if (req_i.op == OP_SET_BIT)
        ctrl_next[req_i.bit_sel] = 1'b1; // [RULE1]
      else if (req_i.op == OP_CLEAR_BIT)
        ctrl_next[req_i.bit_sel] = 1'b0; // [RULE1]
    end
    if (wr_en && dspace >= `EXT_FIRST && in_ext_win(dspace))
      ext_next[ext_idx(dspace)] = req_i.wdata & ext_mask(dspace); // [RULE9]
    flags_next = flags_next | flag_set_i;
    if (rd_en) begin
      rsp_next.valid = 1'b1;
      rsp_next.rdata = rd_val;
    end
    if (bit_ok && req_i.op == OP_TEST_BIT) begin
      rsp_next.valid   = 1'b1;
      rsp_next.bit_val = (io_a == `OFF_LOW_FLAGS) ?
                         flags_reg[req_i.bit_sel] :
                         (io_a == `OFF_LOW_CTRL) ?
                         ctrl_reg[req_i.bit_sel] : 1'b0; // [RULE1]
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_reg <= `RESET_VALUE;
      ctrl_reg  <= `RESET_VALUE;
      rsp_reg   <= '0;
      for (int i = 0; i < 16; i++)
        ext_reg[i] <= `RESET_VALUE;
    end else begin
      flags_reg <= flags_next;
      ctrl_reg  <= ctrl_next;
      rsp_reg   <= rsp_next;
      for (int i = 0; i < 16; i++)
        ext_reg[i] <= ext_next[i];
    end
  end

  always_comb begin
    rsp_o                            = rsp_reg;
    low_flags_o                      = flags_reg;
    low_ctrl_o                       = ctrl_reg;
    adc_input_select_o               = ext_reg[0];
    adc_pin_digital_disable_o        = ext_reg[2];
    comparator_pin_digital_disable_o = ext_reg[3];
    wide_timer_ctrl_a_o              = ext_reg[4];
    wide_timer_ctrl_b_o              = ext_reg[5];
    wide_timer_force_compare_o       = ext_reg[6];
    wide_timer_count_o               = {ext_reg[9], ext_reg[8]};
    wide_timer_capture_o             = {ext_reg[11], ext_reg[10]};
    wide_timer_compare_a_o           = {ext_reg[13], ext_reg[12]};
    wide_timer_compare_b_o           = {ext_reg[15], ext_reg[14]};
  end

  property p_port_ext_blocked;
    @(posedge clock_i) disable iff (!resetn_i)
    (req_i.op == OP_PORT_IN && req_i.addr > `IO_PORT_LAST)
      |=> !rsp_o.valid;
  endproperty
  a_port_ext_blocked: assert property (p_port_ext_blocked) // [RULE6]
    else $error("port read beyond range answered");

  property p_data_offset;
    @(posedge clock_i) disable iff (!resetn_i)
    (req_i.op == OP_DATA_STORE &&
     req_i.addr == 8'(`OFF_LOW_CTRL + `IO_DATA_OFFSET))
      |=> low_ctrl_o == $past(req_i.wdata);
  endproperty
  a_data_offset: assert property (p_data_offset) // [RULE5]
    else $error("data store missed offset mapping");

  property p_w1c;
    @(posedge clock_i) disable iff (!resetn_i)
    (wr_en && io_a == `OFF_LOW_FLAGS && flag_set_i == 8'h00)
      |=> low_flags_o == ($past(low_flags_o) & ~$past(req_i.wdata));
  endproperty
  a_w1c: assert property (p_w1c) // [RULE2]
    else $error("flag write-one-to-clear wrong");

  property p_bitset;
    @(posedge clock_i) disable iff (!resetn_i)
    (req_i.op == OP_SET_BIT && req_i.addr == `OFF_LOW_CTRL)
      |=> low_ctrl_o[$past(req_i.bit_sel)];
  endproperty
  a_bitset: assert property (p_bitset) // [RULE1]
    else $error("bit set failed");

  // Sticky sets from the peripherals would hide a side effect, so excluded
  property p_bit_only;
    @(posedge clock_i) disable iff (!resetn_i)
    (req_i.op == OP_SET_BIT && req_i.addr == `OFF_LOW_FLAGS &&
     flag_set_i == 8'h00)
      |=> (low_flags_o | (8'h01 << $past(req_i.bit_sel))) ==
          ($past(low_flags_o) | (8'h01 << $past(req_i.bit_sel)));
  endproperty
  a_bit_only: assert property (p_bit_only) // [RULE3]
    else $error("bit op touched other flags");

  property p_reserved_zero;
    @(posedge clock_i) disable iff (!resetn_i)
    (req_i.op == OP_DATA_LOAD && req_i.addr == 8'h83)
      |=> rsp_o.rdata == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [RULE9]
    else $error("reserved address read nonzero");

  property p_set_wins;
    @(posedge clock_i) disable iff (!resetn_i)
    (flag_set_i != 8'h00) |=> (low_flags_o & $past(flag_set_i)) ==
                              $past(flag_set_i);
  endproperty
  a_set_wins: assert property (p_set_wins) // [RULE2]
    else $error("flag set lost against clear");

  property p_bit_range;
    @(posedge clock_i) disable iff (!resetn_i)
    (req_i.op == OP_TEST_BIT && req_i.addr > `IO_BIT_LAST)
      |=> !rsp_o.valid;
  endproperty
  a_bit_range: assert property (p_bit_range) // [RULE1]
    else $error("bit test out of range answered");

  c_store_ext: cover property (@(posedge clock_i)
    req_i.op == OP_DATA_STORE && req_i.addr == `OFF_TMR_CNT_H);
  c_test_bit: cover property (@(posedge clock_i)
    req_i.op == OP_TEST_BIT && bit_ok);
  c_w1c: cover property (@(posedge clock_i) wr_en && io_a == `OFF_LOW_FLAGS);
endmodule

// File: include/io_space_params.svh
`ifndef IO_SPACE_PARAMS_SVH
`define IO_SPACE_PARAMS_SVH
`define IO_PORT_LAST        8'h3F
`define IO_BIT_LAST         8'h1F
`define IO_DATA_OFFSET      8'h20
`define EXT_FIRST           8'h60
`define OFF_ADC_SEL         8'h7C
`define OFF_ADC_DIS         8'h7E
`define OFF_CMP_DIS         8'h7F
`define OFF_TMR_CTRL_A      8'h80
`define OFF_TMR_CTRL_B      8'h81
`define OFF_TMR_FORCE       8'h82
`define OFF_TMR_CNT_L       8'h84
`define OFF_TMR_CNT_H       8'h85
`define OFF_TMR_CAP_L       8'h86
`define OFF_TMR_CAP_H       8'h87
`define OFF_TMR_CMPA_L      8'h88
`define OFF_TMR_CMPA_H      8'h89
`define OFF_TMR_CMPB_L      8'h8A
`define OFF_TMR_CMPB_H      8'h8B
`define MASK_ADC_SEL        8'h6F
`define MASK_CMP_DIS        8'h03
`define MASK_TMR_CTRL_A     8'hF3
`define MASK_TMR_CTRL_B     8'hDF
`define MASK_TMR_FORCE      8'hC0
`define OFF_LOW_FLAGS       8'h00
`define OFF_LOW_CTRL        8'h01
`define RESET_VALUE         8'h00
`endif

// File: include/io_space_pkg.sv
package io_space_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_PORT_IN,
    OP_PORT_OUT,
    OP_DATA_LOAD,
    OP_DATA_STORE,
    OP_SET_BIT,
    OP_CLEAR_BIT,
    OP_TEST_BIT
  } io_op_t;

  typedef struct packed {
    io_op_t     op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
    logic       bit_val;
  } io_rsp_t;
endpackage

// File: tb/cpu_model.sv
module cpu_model
  import io_space_pkg::*;
(
  input  wire logic    clock_i,
  input  wire io_rsp_t rsp_i,
  output io_req_t      req_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial req_o = '{OP_NONE, 8'h00, 3'h0, 8'h00};

  // One request held across exactly one taking edge
  task automatic issue(input io_op_t op, input logic [7:0] a,
                       input logic [2:0] b, input logic [7:0] d,
                       output io_rsp_t rsp);
    @(posedge clock_i);
    #1;
    req_o = '{op, a, b, d};
    @(posedge clock_i);
    #1;
    rsp = rsp_i;
    // Idle bus never repeats the last address or data
    req_o = '{OP_NONE, ~a, ~b, ~d};
  endtask
endmodule

// File: tb/tb.sv
module tb;
  import io_space_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  flag_set_i = 8'h00;
  io_req_t     req;
  io_rsp_t     rsp;
  io_rsp_t     r;
  logic [7:0]  lf;
  logic [7:0]  lc;
  logic [7:0]  sel;
  logic [15:0] cmpa;
  logic [7:0]  dis0;
  logic [7:0]  dis1;
  logic [7:0]  ctla;
  logic [7:0]  ctlb;
  logic [7:0]  frc;
  logic [15:0] cnt;
  logic [15:0] cap;
  logic [15:0] cmpb;
  int          err_count = 0;
  int          n_checks = 0;

  always #2.5 clock_i = ~clock_i;

  cpu_model cpu_u (.clock_i(clock_i), .rsp_i(rsp), .req_o(req));

  io_space_regs dut_u (
    .clock_i(clock_i), .resetn_i(resetn_i), .req_i(req),
    .flag_set_i(flag_set_i), .rsp_o(rsp), .low_flags_o(lf),
    .low_ctrl_o(lc), .adc_input_select_o(sel),
    .adc_pin_digital_disable_o(dis0),
    .comparator_pin_digital_disable_o(dis1),
    .wide_timer_ctrl_a_o(ctla), .wide_timer_ctrl_b_o(ctlb),
    .wide_timer_force_compare_o(frc), .wide_timer_count_o(cnt),
    .wide_timer_capture_o(cap), .wide_timer_compare_a_o(cmpa),
    .wide_timer_compare_b_o(cmpb)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic op(input io_op_t o, input logic [7:0] a,
                    input logic [2:0] b, input logic [7:0] d);
    cpu_u.issue(o, a, b, d, r);
  endtask

  task automatic test_ext();
    logic [7:0] ad [14] = '{8'h7C, 8'h7E, 8'h7F, 8'h80, 8'h81, 8'h82,
                            8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89,
                            8'h8A, 8'h8B};
    // Written values keep every reserved bit at zero
    logic [7:0] wv [14] = '{8'h6F, 8'hFF, 8'h03, 8'hF3, 8'hDF, 8'hC0,
                            8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66,
                            8'h77, 8'h88};
    for (int i = 0; i < 14; i++) begin
      op(OP_DATA_LOAD, ad[i], 3'h0, 8'h00);
      chk({r.valid, r.rdata}, 9'h100, "reset value");
      op(OP_DATA_STORE, ad[i], 3'h0, wv[i]);
      op(OP_DATA_LOAD, ad[i], 3'h0, 8'h00);
      chk(r.rdata, wv[i], "readback");
    end
    chk(cmpa, 16'h6655, "compare a bytes");
    chk(cmpb, 16'h8877, "compare b bytes");
    chk(cnt, 16'h2211, "count bytes");
    chk(cap, 16'h4433, "capture bytes");
    chk(dis0, 8'hFF, "adc disable out");
    chk(dis1, 8'h03, "cmp disable out");
    chk(ctla, 8'hF3, "ctrl a out");
    chk(ctlb, 8'hDF, "ctrl b out");
    chk(frc, 8'hC0, "force out");
    chk(sel, 8'h6F, "select out");
    op(OP_PORT_IN, 8'h5C, 3'h0, 8'h00);
    chk(r.valid, 1'b0, "port to ext");
    op(OP_PORT_OUT, 8'h5C, 3'h0, 8'h00);
    chk(sel, 8'h6F, "port write ext");
    $display("test ext done");
  endtask

  task automatic test_map();
    op(OP_PORT_OUT, 8'h01, 3'h0, 8'hA5);
    chk(lc, 8'hA5, "port out");
    op(OP_DATA_LOAD, 8'h21, 3'h0, 8'h00);
    chk(r.rdata, 8'hA5, "data alias");
    op(OP_DATA_STORE, 8'h21, 3'h0, 8'h3C);
    op(OP_PORT_IN, 8'h01, 3'h0, 8'h00);
    chk({r.valid, r.rdata}, 9'h13C, "port in");
    op(OP_PORT_OUT, 8'h41, 3'h0, 8'hFF);
    chk(lc, 8'h3C, "port beyond range");
    op(OP_PORT_IN, 8'h3F, 3'h0, 8'h00);
    chk(r.valid, 1'b1, "last port");
    $display("test map done");
  endtask

  task automatic test_bits();
    @(posedge clock_i);
    #1;
    flag_set_i = 8'hFF;
    @(posedge clock_i);
    #1;
    flag_set_i = 8'h00;
    op(OP_PORT_OUT, 8'h00, 3'h0, 8'h0F);
    chk(lf, 8'hF0, "one clears");
    op(OP_DATA_STORE, 8'h20, 3'h0, 8'h00);
    chk(lf, 8'hF0, "zero keeps");
    op(OP_SET_BIT, 8'h00, 3'h4, 8'h00);
    chk(lf, 8'hE0, "bit set on flags");
    op(OP_CLEAR_BIT, 8'h00, 3'h5, 8'h00);
    chk(lf, 8'hE0, "bit clear on flags");
    op(OP_TEST_BIT, 8'h00, 3'h7, 8'h00);
    chk({r.valid, r.bit_val}, 2'b11, "test set");
    op(OP_TEST_BIT, 8'h00, 3'h4, 8'h00);
    chk({r.valid, r.bit_val}, 2'b10, "test clear");
    op(OP_SET_BIT, 8'h01, 3'h0, 8'h00);
    chk(lc, 8'h3D, "bit set");
    op(OP_CLEAR_BIT, 8'h01, 3'h2, 8'h00);
    chk(lc, 8'h39, "bit clear");
    op(OP_SET_BIT, 8'h21, 3'h1, 8'h00);
    chk(lc, 8'h39, "bit op high");
    op(OP_TEST_BIT, 8'h20, 3'h0, 8'h00);
    chk(r.valid, 1'b0, "test high");
    $display("test bits done");
  endtask

  task automatic test_rsvd();
    logic [7:0] ad [3] = '{8'h7D, 8'h83, 8'h8C};
    // Loads only: reserved addresses are never written
    for (int i = 0; i < 3; i++) begin
      op(OP_DATA_LOAD, ad[i], 3'h0, 8'h00);
      chk({r.valid, r.rdata}, 9'h100, "reserved");
    end
    chk(cmpa, 16'h6655, "no alias");
    $display("test rsvd done");
  endtask

  task automatic test_reset();
    @(posedge clock_i);
    #1;
    resetn_i = 1'b0;
    @(posedge clock_i);
    #1;
    chk(lf, 8'h00, "flags in reset");
    chk(lc, 8'h00, "ctrl in reset");
    chk(cmpb, 16'h0000, "compare in reset");
    chk(rsp.valid, 1'b0, "answer in reset");
    resetn_i = 1'b1;
    op(OP_DATA_LOAD, 8'h8A, 3'h0, 8'h00);
    chk({r.valid, r.rdata}, 9'h100, "first load");
    $display("test reset done");
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    test_ext();
    test_map();
    test_bits();
    test_rsvd();
    test_reset();
    test_done();
  end

  initial begin
    #20000;
    err_count++;
    test_done();
  end
endmodule
